// *** core_cfg.svh ***
// Constants for the instruction execution core: offsets, field positions, reset values, timing
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH
`define SYS_PER_CYCLE  4
`define REG_CTRL       8'h00
`define REG_INSTR      8'h04
`define REG_STATUS     8'h08
`define REG_ACC        8'h0C
`define REG_PC         8'h10
`define REG_DM_ADDR    8'h14
`define REG_DM_DATA    8'h18
`define REG_PM_ADDR    8'h1C
`define REG_PM_DATA    8'h20
`define REG_CYCLES     8'h24
`define CTRL_WD_TWO    0
`define CTRL_WAKE      1
`define PC_LOW_ADDR    8'h02
`define TBL_PTR_ADDR   8'h07
`define LAST_PAGE      4'hF
`define STACK_DEPTH    8
`define PC_RST         12'h000
`define ACC_RST        8'h00
`define WD_MAX         16'hFFFF
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// *** core_pkg.sv ***
// Types shared by the instruction execution core
package core_pkg;
	typedef enum logic [5:0] {
		OP_NOP, OP_ADD, OP_ADD_C, OP_SUB, OP_SUB_B, OP_DEC_ADJ, OP_AND, OP_OR, OP_XOR,
		OP_COMPL, OP_INC, OP_DEC, OP_ROT_R, OP_ROT_L, OP_ROTC_R, OP_ROTC_L,
		OP_MOV_AM, OP_MOV_MA, OP_MOV_AI, OP_BIT_CLR, OP_BIT_SET, OP_CLR_M, OP_SET_M, OP_SWAP,
		OP_SKIP_Z, OP_SKIP_ZA, OP_SKIP_BCLR, OP_SKIP_BSET, OP_INC_SKIP, OP_DEC_SKIP,
		OP_JUMP, OP_CALL, OP_EXIT, OP_EXIT_LOAD, OP_EXIT_INT, OP_TAB_CUR, OP_TAB_LAST,
		OP_WD_CLEAR, OP_WD_PRE1, OP_WD_PRE2, OP_HALT
	} op_t;
	typedef struct packed {
		op_t         op;
		logic        to_mem;
		logic        use_imm;
		logic [2:0]  bit_sel;
		logic [11:0] operand;
	} instr_t;
	typedef struct packed {
		logic timeout;
		logic powerdown;
		logic wrap;
		logic half;
		logic carry;
		logic zero;
	} flags_t;
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_HALT} state_t;
endpackage : core_pkg

// *** cycle_divider.sv ***
// Divides the system clock into four-phase instruction cycles
`timescale 1ns/1ns
`include "core_cfg.svh"
module cycle_divider (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Control and phase
	input  wire logic       run,
	output logic      [1:0] phase,
	output logic            tick
);
	// Phase restarts on every new instruction so the cycle edge is exact
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	assign tick = run && (phase == 2'(`SYS_PER_CYCLE - 1));
endmodule : cycle_divider

// *** alu_unit.sv ***
// Result and flag computation for one instruction
`timescale 1ns/1ns
module alu_unit (
	// Operands
	input  core_pkg::instr_t  ir,
	input  wire logic   [7:0] a,
	input  wire logic   [7:0] m,
	input  core_pkg::flags_t  fin,
	// Results
	output logic        [7:0] res,
	output core_pkg::flags_t  fout
);
	import core_pkg::*;
	logic [7:0] b;
	logic [7:0] add_b;
	logic [7:0] adj;
	logic       add_cin;
	logic       z_op;
	logic [8:0] sum;
	logic [8:0] dsum;
	logic [4:0] hsum;

	always_comb begin
		b = ir.use_imm ? ir.operand[7:0] : m;
		add_b = (ir.op == OP_SUB || ir.op == OP_SUB_B) ? ~b : b;
		add_cin = (ir.op == OP_SUB) || ((ir.op == OP_ADD_C || ir.op == OP_SUB_B) && fin.carry);
		adj = {((a[7:4] > 4'h9) || fin.carry) ? 4'h6 : 4'h0,
			((a[3:0] > 4'h9) || fin.half) ? 4'h6 : 4'h0};
	end

	assign sum = {1'b0, a} + {1'b0, add_b} + {8'h00, add_cin};
	assign hsum = {1'b0, a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
	assign dsum = {1'b0, a} + {1'b0, adj};

	always_comb begin
		fout = fin;
		z_op = 1'b0;
		res = m;
		unique case (ir.op)
			OP_ADD, OP_ADD_C, OP_SUB, OP_SUB_B: begin
				res = sum[7:0];
				fout.carry = sum[8];
				fout.half = hsum[4];
				fout.wrap = (a[7] == add_b[7]) && (sum[7] != a[7]);
				z_op = 1'b1;
			end
			OP_DEC_ADJ: begin
				res = dsum[7:0];
				fout.carry = fin.carry || dsum[8];
			end
			OP_AND: begin res = a & b; z_op = 1'b1; end
			OP_OR: begin res = a | b; z_op = 1'b1; end
			OP_XOR: begin res = a ^ b; z_op = 1'b1; end
			OP_COMPL: begin res = ~m; z_op = 1'b1; end
			OP_INC: begin res = m + 8'h01; z_op = 1'b1; end
			OP_DEC: begin res = m - 8'h01; z_op = 1'b1; end
			OP_INC_SKIP: res = m + 8'h01;
			OP_DEC_SKIP: res = m - 8'h01;
			OP_ROT_R: res = {m[0], m[7:1]};
			OP_ROT_L: res = {m[6:0], m[7]};
			OP_ROTC_R: begin res = {fin.carry, m[7:1]}; fout.carry = m[0]; end
			OP_ROTC_L: begin res = {m[6:0], fin.carry}; fout.carry = m[7]; end
			OP_MOV_MA: res = a;
			OP_MOV_AI, OP_EXIT_LOAD: res = ir.operand[7:0];
			OP_BIT_CLR: res = m & ~(8'h01 << ir.bit_sel);
			OP_BIT_SET: res = m | (8'h01 << ir.bit_sel);
			OP_CLR_M: res = 8'h00;
			OP_SET_M: res = 8'hFF;
			OP_SWAP: res = {m[3:0], m[7:4]};
			default: res = m;
		endcase
		if (z_op) begin
			fout.zero = (res == 8'h00);
		end
	end
endmodule : alu_unit

// *** exec_core.sv ***
// Instruction execution core with AXI4-Lite register access
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "core_cfg.svh"
module exec_core (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic  [7:0] awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic  [3:0] wstrb,
	// AXI4-Lite write response
	output logic             bvalid,
	input  wire logic        bready,
	output logic       [1:0] bresp,
	// AXI4-Lite read
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic  [7:0] araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic      [31:0] rdata,
	output logic       [1:0] rresp,
	// Core state
	output logic             halted
);
	import core_pkg::*;

	state_t      state;
	instr_t      ir;
	flags_t      flags;
	flags_t      alu_flags;
	logic  [7:0] acc;
	logic  [6:0] tbl_high;
	logic  [7:0] alu_res;
	logic  [7:0] m_val;
	logic  [7:0] mem_data;
	logic [11:0] pc;
	logic [11:0] next_pc;
	logic [11:0] tab_addr;
	logic [14:0] pm_word;
	logic [14:0] pm [0:4095];
	logic  [7:0] dm [0:255];
	logic [11:0] stack [0:`STACK_DEPTH-1];
	logic  [2:0] sp;
	logic  [1:0] phase;
	logic        cycle_tick;
	logic        second;
	logic        two_cycle;
	logic        skip;
	logic        skip_op;
	logic        wr_acc;
	logic        wr_mem;
	logic        pc_low_write;
	logic        commit;
	logic        issue;
	logic        wake;
	logic        wd_two;
	logic        pre1_last;
	logic        pre2_last;
	logic        wd_clear;
	logic        wd_over;
	logic [15:0] wd_count;
	logic [31:0] cycles;
	logic  [7:0] dm_ptr;
	logic [11:0] pm_ptr;
	logic        aw_held;
	logic        w_held;
	logic  [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic        do_write;
	logic [31:0] rd_mux;
	logic        rd_ok;

	cycle_divider u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (state == ST_EXEC),
		.phase   (phase),
		.tick    (cycle_tick)
	);

	alu_unit u_alu (
		.ir   (ir),
		.a    (acc),
		.m    (m_val),
		.fin  (flags),
		.res  (alu_res),
		.fout (alu_flags)
	);

	// Program counter low reads back the live counter, not the memory cell
	assign m_val = (ir.operand[7:0] == `PC_LOW_ADDR) ? pc[7:0] : dm[ir.operand[7:0]];
	assign tab_addr = (ir.op == OP_TAB_LAST) ? {`LAST_PAGE, dm[`TBL_PTR_ADDR]}
		: {pc[11:8], dm[`TBL_PTR_ADDR]};
	assign pm_word = pm[tab_addr];
	assign mem_data = (ir.op == OP_TAB_CUR || ir.op == OP_TAB_LAST) ? pm_word[7:0] : alu_res;

	always_comb begin
		wr_acc = 1'b0;
		wr_mem = 1'b0;
		skip = 1'b0;
		skip_op = 1'b0;
		unique case (ir.op)
			OP_ADD, OP_ADD_C, OP_SUB, OP_SUB_B, OP_AND, OP_OR, OP_XOR: begin
				wr_mem = ir.to_mem && !ir.use_imm;
				wr_acc = !wr_mem;
			end
			OP_COMPL, OP_INC, OP_DEC, OP_ROT_R, OP_ROT_L, OP_ROTC_R, OP_ROTC_L, OP_SWAP: begin
				wr_mem = ir.to_mem;
				wr_acc = !ir.to_mem;
			end
			OP_DEC_ADJ, OP_MOV_MA, OP_BIT_CLR, OP_BIT_SET, OP_CLR_M, OP_SET_M,
			OP_TAB_CUR, OP_TAB_LAST: wr_mem = 1'b1;
			OP_MOV_AM, OP_MOV_AI, OP_EXIT_LOAD: wr_acc = 1'b1;
			OP_SKIP_Z: begin
				skip_op = 1'b1;
				skip = (m_val == 8'h00);
			end
			OP_SKIP_ZA: begin
				skip_op = 1'b1;
				wr_acc = 1'b1;
				skip = (m_val == 8'h00);
			end
			OP_SKIP_BCLR: begin
				skip_op = 1'b1;
				skip = !m_val[ir.bit_sel];
			end
			OP_SKIP_BSET: begin
				skip_op = 1'b1;
				skip = m_val[ir.bit_sel];
			end
			OP_INC_SKIP, OP_DEC_SKIP: begin
				skip_op = 1'b1;
				wr_mem = ir.to_mem;
				wr_acc = !ir.to_mem;
				skip = (alu_res == 8'h00);
			end
			default: ;
		endcase
	end

	assign pc_low_write = wr_mem && (ir.operand[7:0] == `PC_LOW_ADDR);

	assign two_cycle = skip || pc_low_write || (ir.op inside {OP_JUMP, OP_CALL, OP_EXIT,
		OP_EXIT_LOAD, OP_EXIT_INT, OP_TAB_CUR, OP_TAB_LAST});

	always_comb begin
		next_pc = pc + 12'h001;
		if (ir.op == OP_JUMP || ir.op == OP_CALL) begin
			next_pc = ir.operand;
		end else if (ir.op inside {OP_EXIT, OP_EXIT_LOAD, OP_EXIT_INT}) begin
			next_pc = stack[sp - 3'h1];
		end else if (pc_low_write) begin
			next_pc = {pc[11:8], mem_data};
		end else if (skip) begin
			next_pc = pc + 12'h002;
		end
	end

	// retire on the last phase of the last cycle
	assign commit = cycle_tick && (!two_cycle || second);

	always_ff @(posedge aclk) begin
		if (!aresetn || commit) begin
			second <= 1'b0;
		end else if (cycle_tick) begin
			second <= 1'b1;
		end
	end

	assign do_write = aw_held && w_held && !bvalid;
	assign issue = do_write && (aw_addr_q == `REG_INSTR) && (state == ST_IDLE);
	assign wake = do_write && (aw_addr_q == `REG_CTRL) && w_data_q[`CTRL_WAKE];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			halted <= 1'b0;
			ir <= '0;
		end else begin
			unique case (state)
				ST_IDLE: if (issue) begin
					ir <= instr_t'(w_data_q[$bits(instr_t)-1:0]);
					state <= ST_EXEC;
				end
				ST_EXEC: if (commit) begin
					state <= (ir.op == OP_HALT) ? ST_HALT : ST_IDLE;
					halted <= (ir.op == OP_HALT);
				end
				ST_HALT: if (wake) begin
					state <= ST_IDLE;
					halted <= 1'b0;
				end
			endcase
		end
	end

	// Architectural state; the bus may write data memory only between instructions
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc <= `ACC_RST;
			pc <= `PC_RST;
			sp <= 3'h0;
			tbl_high <= 7'h00;
		end else if (commit) begin
			pc <= next_pc;
			if (wr_acc) begin
				acc <= (ir.op == OP_SKIP_ZA || ir.op == OP_MOV_AM) ? m_val : alu_res;
			end
			if (wr_mem && !pc_low_write) begin
				dm[ir.operand[7:0]] <= mem_data;
			end
			if (ir.op == OP_TAB_CUR || ir.op == OP_TAB_LAST) begin
				tbl_high <= pm_word[14:8];
			end
			if (ir.op == OP_CALL) begin
				stack[sp] <= pc + 12'h001;
				sp <= sp + 3'h1;
			end
			if (ir.op inside {OP_EXIT, OP_EXIT_LOAD, OP_EXIT_INT}) begin
				sp <= sp - 3'h1;
			end
		end else if (do_write && state != ST_EXEC && aw_addr_q == `REG_DM_DATA) begin
			dm[dm_ptr] <= w_data_q[7:0];
		end
	end

	// flags from the result unit, moves pass them through unchanged
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= '0;
		end else begin
			if (commit) begin
				flags <= alu_flags;
			end
			if (commit && ir.op == OP_HALT) begin
				flags.powerdown <= 1'b1;
				flags.timeout <= 1'b0;
			end else if (wd_clear) begin
				flags.powerdown <= 1'b0;
				flags.timeout <= 1'b0;
			end
			// A timeout in the same cycle as a clear is kept
			if (wd_over) begin
				flags.timeout <= 1'b1;
			end
		end
	end

	assign wd_clear = commit && ((!wd_two && ir.op == OP_WD_CLEAR)
		|| (wd_two && ((ir.op == OP_WD_PRE2 && pre1_last) || (ir.op == OP_WD_PRE1 && pre2_last))));
	assign wd_over = cycle_tick && (wd_count == `WD_MAX);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre1_last <= 1'b0;
			pre2_last <= 1'b0;
		end else if (commit) begin
			pre1_last <= (ir.op == OP_WD_PRE1);
			pre2_last <= (ir.op == OP_WD_PRE2);
		end
	end

	// Watchdog counts executed instruction cycles only
	always_ff @(posedge aclk) begin
		if (!aresetn || wd_clear || (commit && ir.op == OP_HALT)) begin
			wd_count <= 16'h0000;
		end else if (cycle_tick) begin
			wd_count <= wd_count + 16'h0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cycles <= 32'h0000_0000;
		end else if (cycle_tick) begin
			cycles <= cycles + 32'h0000_0001;
		end
	end

	// Configuration and memory pointers; byte strobes are not honoured
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wd_two <= 1'b0;
			dm_ptr <= 8'h00;
			pm_ptr <= 12'h000;
		end else if (do_write) begin
			if (aw_addr_q == `REG_CTRL) begin
				wd_two <= w_data_q[`CTRL_WD_TWO];
			end
			if (aw_addr_q == `REG_DM_ADDR) begin
				dm_ptr <= w_data_q[7:0];
			end
			if (aw_addr_q == `REG_PM_ADDR) begin
				pm_ptr <= w_data_q[11:0];
			end
			if (aw_addr_q == `REG_PM_DATA && state != ST_EXEC) begin
				pm[pm_ptr] <= w_data_q[14:0];
			end
		end
	end

	// Write channels are taken independently, the response follows both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				awready <= 1'b0;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				wready <= 1'b0;
				w_data_q <= wdata;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
				bvalid <= 1'b1;
				bresp <= (aw_addr_q > `REG_CYCLES || aw_addr_q[1:0] != 2'h0)
					? `RESP_SLVERR : `RESP_OKAY;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_ok = 1'b1;
		unique case (araddr)
			`REG_CTRL: rd_mux[`CTRL_WD_TWO] = wd_two;
			`REG_INSTR: rd_mux[$bits(instr_t)-1:0] = ir;
			`REG_STATUS: rd_mux[7:0] = {state == ST_EXEC, halted, flags};
			`REG_ACC: rd_mux[14:0] = {tbl_high, acc};
			`REG_PC: rd_mux[14:0] = {sp, pc};
			`REG_DM_ADDR: rd_mux[7:0] = dm_ptr;
			`REG_DM_DATA: rd_mux[7:0] = (dm_ptr == `PC_LOW_ADDR) ? pc[7:0] : dm[dm_ptr];
			`REG_PM_ADDR: rd_mux[11:0] = pm_ptr;
			`REG_PM_DATA: rd_mux[14:0] = pm[pm_ptr];
			`REG_CYCLES: rd_mux = cycles;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Clocks spent in the current instruction, for checking only
	logic [3:0] exec_len;
	logic [1:0] wd_flags;
	assign wd_flags = {flags.timeout, flags.powerdown};
	always_ff @(posedge aclk) begin
		if (!aresetn || state != ST_EXEC) begin
			exec_len <= 4'h0;
		end else begin
			exec_len <= exec_len + 4'h1;
		end
	end

	property p_cycle_len;
		@(posedge aclk) disable iff (!aresetn)
		commit |-> exec_len == (two_cycle ? 4'd7 : 4'd3);
	endproperty
	a_cycle_len: assert property (p_cycle_len) else $error("instruction length wrong");

	property p_branch_two;
		@(posedge aclk) disable iff (!aresetn)
		commit && (ir.op inside {OP_JUMP, OP_CALL, OP_EXIT, OP_EXIT_INT, OP_TAB_CUR})
		|-> exec_len == 4'd7;
	endproperty
	a_branch_two: assert property (p_branch_two) else $error("branch not two cycles");

	property p_pc_low_jump;
		@(posedge aclk) disable iff (!aresetn)
		commit && pc_low_write |-> exec_len == 4'd7 ##1 pc[7:0] == $past(mem_data);
	endproperty
	a_pc_low_jump: assert property (p_pc_low_jump) else $error("low byte jump timing");

	property p_skip_one;
		@(posedge aclk) disable iff (!aresetn)
		commit && skip_op && !skip |-> exec_len == 4'd3;
	endproperty
	a_skip_one: assert property (p_skip_one) else $error("untaken skip not one cycle");

	property p_move_flags;
		@(posedge aclk) disable iff (!aresetn)
		commit && !wd_over && (ir.op inside {OP_MOV_AM, OP_MOV_MA, OP_MOV_AI})
		|=> $stable(flags);
	endproperty
	a_move_flags: assert property (p_move_flags) else $error("move changed flags");

	property p_pair_hold;
		@(posedge aclk) disable iff (!aresetn)
		commit && wd_two && !wd_over && ir.op == OP_WD_PRE1 && !pre2_last |=> $stable(wd_flags);
	endproperty
	a_pair_hold: assert property (p_pair_hold) else $error("lone preclear changed flags");

	property p_halt;
		@(posedge aclk) disable iff (!aresetn)
		commit && !wd_over && ir.op == OP_HALT
		|=> halted && wd_flags == 2'b01 && wd_count == 16'h0000 ##1 state == ST_HALT;
	endproperty
	a_halt: assert property (p_halt) else $error("halt entry wrong");

	property p_zero;
		@(posedge aclk) disable iff (!aresetn)
		commit && wr_acc && (ir.op inside {OP_AND, OP_OR, OP_XOR, OP_ADD})
		|=> flags.zero == (acc == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag mismatch");

	c_skip_taken: cover property (@(posedge aclk) disable iff (!aresetn) commit && skip);
	c_halt: cover property (@(posedge aclk) disable iff (!aresetn) commit && ir.op == OP_HALT);
	c_call: cover property (@(posedge aclk) disable iff (!aresetn) commit && ir.op == OP_CALL);
	c_pair: cover property (@(posedge aclk) disable iff (!aresetn) wd_clear && wd_two);
endmodule : exec_core

// *** axi_host.sv ***
// AXI4-Lite master model that drives the core's register bus
`timescale 1ns/1ns
module axi_host (
	// Clock
	input  wire logic        aclk,
	// Write channels
	output logic             awvalid,
	input  wire logic        awready,
	output logic       [7:0] awaddr,
	output logic             wvalid,
	input  wire logic        wready,
	output logic      [31:0] wdata,
	output logic       [3:0] wstrb,
	input  wire logic        bvalid,
	output logic             bready,
	input  wire logic  [1:0] bresp,
	// Read channels
	output logic             arvalid,
	input  wire logic        arready,
	output logic       [7:0] araddr,
	input  wire logic        rvalid,
	output logic             rready,
	input  wire logic [31:0] rdata,
	input  wire logic  [1:0] rresp,
	// Hang report
	output logic             stuck
);
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, stuck} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
	end
	// Released payload is inverted so a stale value is never mistaken for a live one
	task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		r = 2'h3;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr  <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata  <= ~d;
			end
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (i == 64)
			stuck <= 1'b1;
	endtask : write
	task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		d = 32'hFFFFFFFF;
		r = 2'h3;
		for (i = 0; i < 64; i++) begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr  <= ~a;
			end
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (i == 64)
			stuck <= 1'b1;
	endtask : read
endmodule : axi_host

// *** mcu_instruction_execution_timing_tb.sv ***
// Self-checking bench for the instruction execution core
`timescale 1ns/1ns
`include "core_cfg.svh"
module mcu_instruction_execution_timing_tb;
	import core_pkg::*;
	typedef struct packed {
		op_t        op;
		logic [4:0] md;
		logic [7:0] adr;
		logic [7:0] a;
		logic [7:0] m;
		logic [7:0] eacc;
		logic [7:0] emem;
		logic [5:0] efl;
		logic [1:0] ecyc;
	} row_t;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, halted, stuck;
	logic  [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v, c0;
	logic  [3:0] wstrb;
	logic  [1:0] bresp, rresp, rr;
	int          n_errors, n_tests, k;
	row_t        r;
	row_t        rows [0:31];
	exec_core dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .halted(halted));
	axi_host host (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.stuck(stuck));
	always #2 aclk = ~aclk;
	task tally_and_finish;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	task hang;
		n_errors++;
		$display("[FAIL] %0t wait ran out", $time);
		tally_and_finish();
	endtask : hang
	always @(posedge stuck) hang();
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic do_reset;
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : do_reset
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.write(a, d, rr);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		host.read(a, d, rr);
	endtask : rd
	// Issue one instruction and poll busy until it retires
	task automatic exec(input op_t op, input logic [4:0] md, input logic [11:0] opd);
		logic [31:0] s;
		int          i;
		wr(`REG_INSTR, {9'h0, op, md, opd});
		for (i = 0; i < 40; i++) begin
			rd(`REG_STATUS, s);
			if (s[7] === 1'b0)
				break;
		end
		if (i == 40)
			hang();
	endtask : exec
	initial begin
		aclk = 1'b0;
		{n_errors, n_tests} = 0;
		// Fields: op, {to_mem,imm,bit}, address or immediate, acc, mem, acc, mem, flags, cycles
		rows = '{
			'{OP_ADD, 5'h00, 8'h40, 8'h7F, 8'h01, 8'h80, 8'h01, 6'h0C, 2'h1},
			'{OP_ADD, 5'h10, 8'h40, 8'h80, 8'h80, 8'h80, 8'h00, 6'h0B, 2'h1},
			'{OP_SUB, 5'h00, 8'h40, 8'h13, 8'h01, 8'h12, 8'h01, 6'h06, 2'h1},
			'{OP_SUB_B, 5'h10, 8'h40, 8'h05, 8'h05, 8'h05, 8'hFF, 6'h00, 2'h1},
			'{OP_AND, 5'h08, 8'h0F, 8'hF0, 8'h00, 8'h00, 8'h00, 6'h01, 2'h1},
			'{OP_XOR, 5'h10, 8'h40, 8'hFF, 8'h0F, 8'hFF, 8'hF0, 6'h00, 2'h1},
			'{OP_COMPL, 5'h00, 8'h40, 8'h11, 8'hFF, 8'h00, 8'hFF, 6'h01, 2'h1},
			'{OP_INC, 5'h10, 8'h40, 8'h11, 8'hFF, 8'h11, 8'h00, 6'h01, 2'h1},
			'{OP_ROT_L, 5'h00, 8'h40, 8'h11, 8'h81, 8'h03, 8'h81, 6'h00, 2'h1},
			'{OP_ROTC_R, 5'h10, 8'h40, 8'h11, 8'h01, 8'h11, 8'h00, 6'h02, 2'h1},
			'{OP_SWAP, 5'h10, 8'h40, 8'h11, 8'h3C, 8'h11, 8'hC3, 6'h00, 2'h1},
			'{OP_BIT_SET, 5'h12, 8'h40, 8'h11, 8'h00, 8'h11, 8'h04, 6'h00, 2'h1},
			'{OP_BIT_CLR, 5'h17, 8'h40, 8'h11, 8'hFF, 8'h11, 8'h7F, 6'h00, 2'h1},
			'{OP_DEC_ADJ, 5'h10, 8'h40, 8'hA0, 8'h00, 8'hA0, 8'h00, 6'h02, 2'h1},
			'{OP_SKIP_Z, 5'h00, 8'h40, 8'h11, 8'h00, 8'h11, 8'h00, 6'h00, 2'h2},
			'{OP_SKIP_Z, 5'h00, 8'h40, 8'h11, 8'h05, 8'h11, 8'h05, 6'h00, 2'h1},
			'{OP_INC_SKIP, 5'h10, 8'h40, 8'h11, 8'hFF, 8'h11, 8'h00, 6'h00, 2'h2},
			'{OP_DEC_SKIP, 5'h00, 8'h40, 8'h11, 8'h02, 8'h01, 8'h02, 6'h00, 2'h1},
			'{OP_SKIP_BSET, 5'h03, 8'h40, 8'h11, 8'h08, 8'h11, 8'h08, 6'h00, 2'h2},
			'{OP_MOV_MA, 5'h10, 8'h02, 8'h40, 8'h00, 8'h40, 8'h40, 6'h00, 2'h2},
			'{OP_JUMP, 5'h00, 8'h55, 8'h11, 8'h00, 8'h11, 8'h00, 6'h00, 2'h2},
			'{OP_EXIT_LOAD, 5'h08, 8'h55, 8'h11, 8'h00, 8'h55, 8'h00, 6'h00, 2'h2},
			'{OP_OR, 5'h08, 8'h0F, 8'hF0, 8'h00, 8'hFF, 8'h00, 6'h00, 2'h1},
			'{OP_ADD_C, 5'h00, 8'h40, 8'h01, 8'hFF, 8'h00, 8'hFF, 6'h07, 2'h1},
			'{OP_DEC, 5'h10, 8'h40, 8'h11, 8'h01, 8'h11, 8'h00, 6'h01, 2'h1},
			'{OP_ROT_R, 5'h10, 8'h40, 8'h11, 8'h01, 8'h11, 8'h80, 6'h00, 2'h1},
			'{OP_ROTC_L, 5'h00, 8'h40, 8'h11, 8'h80, 8'h00, 8'h80, 6'h02, 2'h1},
			'{OP_MOV_AM, 5'h00, 8'h40, 8'h11, 8'h5A, 8'h5A, 8'h5A, 6'h00, 2'h1},
			'{OP_SKIP_ZA, 5'h00, 8'h40, 8'h11, 8'h00, 8'h00, 8'h00, 6'h00, 2'h2},
			'{OP_SKIP_BCLR, 5'h00, 8'h40, 8'h11, 8'hFE, 8'h11, 8'hFE, 6'h00, 2'h2},
			'{OP_CLR_M, 5'h10, 8'h40, 8'h11, 8'hA5, 8'h11, 8'h00, 6'h00, 2'h1},
			'{OP_SET_M, 5'h10, 8'h40, 8'h11, 8'h00, 8'h11, 8'hFF, 6'h00, 2'h1}};
		// Fresh reset per row so the starting flags are known to be zero
		for (k = 0; k < 32; k++) begin
			r = rows[k];
			do_reset();
			wr(`REG_DM_ADDR, {24'h0, r.adr});
			wr(`REG_DM_DATA, {24'h0, r.m});
			exec(OP_MOV_AI, 5'h08, {4'h0, r.a});
			rd(`REG_CYCLES, c0);
			exec(r.op, r.md, {4'h0, r.adr});
			rd(`REG_CYCLES, v);
			chk(v - c0, {30'h0, r.ecyc});
			rd(`REG_ACC, v);
			chk({24'h0, v[7:0]}, {24'h0, r.eacc});
			rd(`REG_DM_DATA, v);
			chk({24'h0, v[7:0]}, {24'h0, r.emem});
			rd(`REG_STATUS, v);
			chk({26'h0, v[5:0]}, {26'h0, r.efl});
			$display("row %0d done", k);
		end
		do_reset();
		rd(`REG_STATUS, v);
		chk(v, 32'h0);
		rd(`REG_PC, v);
		chk(v, 32'h0);
		host.read(8'h3C, v, rr);
		chk(v, 32'h0);
		chk({30'h0, rr}, {30'h0, `RESP_SLVERR});
		host.write(8'h3C, 32'h5, rr);
		chk({30'h0, rr}, {30'h0, `RESP_SLVERR});
		$display("reset and unmapped test done");
		// Call, return and both table reads, starting from the reset pc
		exec(OP_CALL, 5'h00, 12'h123);
		rd(`REG_PC, v);
		chk(v, 32'h0000_1123);
		exec(OP_EXIT, 5'h00, 12'h000);
		rd(`REG_PC, v);
		chk(v, 32'h0000_0001);
		wr(`REG_DM_ADDR, 32'h0000_0007);
		wr(`REG_DM_DATA, 32'h0000_0034);
		wr(`REG_PM_ADDR, 32'h0000_0034);
		wr(`REG_PM_DATA, 32'h0000_5A5A);
		wr(`REG_PM_ADDR, 32'h0000_0F34);
		wr(`REG_PM_DATA, 32'h0000_0123);
		exec(OP_TAB_CUR, 5'h00, 12'h040);
		rd(`REG_ACC, v);
		chk(v, 32'h0000_5A00);
		exec(OP_TAB_LAST, 5'h00, 12'h041);
		rd(`REG_ACC, v);
		chk(v, 32'h0000_0100);
		wr(`REG_DM_ADDR, 32'h0000_0040);
		rd(`REG_DM_DATA, v);
		chk(v, 32'h0000_005A);
		wr(`REG_DM_ADDR, 32'h0000_0041);
		rd(`REG_DM_DATA, v);
		chk(v, 32'h0000_0023);
		$display("call and table test done");
		exec(OP_HALT, 5'h00, 12'h000);
		chk({31'h0, halted}, 32'h1);
		rd(`REG_STATUS, v);
		chk({30'h0, v[5:4]}, 32'h1);
		wr(`REG_CTRL, 32'h2);
		exec(OP_WD_CLEAR, 5'h00, 12'h000);
		rd(`REG_STATUS, v);
		chk({30'h0, v[5:4]}, 32'h0);
		wr(`REG_CTRL, 32'h1);
		exec(OP_HALT, 5'h00, 12'h000);
		wr(`REG_CTRL, 32'h3);
		exec(OP_WD_PRE1, 5'h00, 12'h000);
		rd(`REG_STATUS, v);
		chk({30'h0, v[5:4]}, 32'h1);
		exec(OP_WD_PRE2, 5'h00, 12'h000);
		rd(`REG_STATUS, v);
		chk({30'h0, v[5:4]}, 32'h0);
		$display("watchdog test done");
		tally_and_finish();
	end
endmodule : mcu_instruction_execution_timing_tb
